// ---- adk_ctrl_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "adk_defs.svh"
module adk_ctrl_regs
	import adk_pkg::*;
#(
	parameter int unsigned CLK_KHZ    = `ADK_CLK_KHZ,
	parameter int unsigned DET_CYCLES = 64
)(
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic         reg_wr,
	input  wire logic         reg_rd,
	input  wire logic [7:0]   reg_addr,
	input  wire logic [7:0]   reg_wdata,
	output logic [7:0]        reg_rdata,
	input  wire logic [7:0]   int_status,
	input  wire logic         accessory_sense_input_n,
	input  wire logic         accessory_removed,
	input  wire adk_switch_t  switch_ctl,
	input  wire adk_switch_t  switch_auto,
	input  wire logic [1:0]   third_switch_matrix,
	input  wire adk_key_evt_t key_evt,
	output adk_switch_t       switch_state,
	output logic              depletion_on,
	output logic              detect_busy,
	output logic              detect_done,
	output logic              button_detect_run,
	output logic              conv_start,
	output logic              key_press_flag,
	output logic              key_release_flag,
	output logic              conv_flag,
	output logic [7:0]        conv_result,
	output logic              device_reset
);
	localparam int unsigned CYC_PER_MS = CLK_KHZ;
	localparam int unsigned CNT_W = 32;

	logic [7:0]     detctl;
	logic [2:0]     keyctl;
	adk_det_state_t state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] settle_cycles;
	logic           sense_d;
	logic           inserted;
	logic           insert_edge;
	logic           wr_det;
	logic           wr_key;
	logic           soft_rst;
	logic           req_ok;
	logic           conv_busy;
	logic           sense_on;
	logic           raw_on;

	assign inserted    = ~accessory_sense_input_n;
	assign insert_edge = inserted & sense_d;
	assign wr_det      = reg_wr && reg_addr == `ADK_OFS_DETCTL;
	assign wr_key      = reg_wr && reg_addr == `ADK_OFS_KEYCTL;
	assign soft_rst    = wr_det && reg_wdata[`ADK_DET_SWRST];
	assign device_reset = soft_rst;
	assign sense_on    = keyctl[`ADK_KEY_SENSE];
	assign raw_on      = keyctl[`ADK_KEY_RAW];
	assign detect_busy = state != ADK_IDLE;

	// Request is ignored when busy, status pending or jack empty
	assign req_ok = wr_det && reg_wdata[`ADK_DET_REQ] && !detect_busy
		&& int_status == 8'h00
		&& inserted;

	always_comb
	begin
		case (detctl[2:0])
			3'h0: settle_cycles = CNT_W'(`ADK_T0_MS * CYC_PER_MS);
			3'h1: settle_cycles = CNT_W'(`ADK_T1_MS * CYC_PER_MS);
			3'h2: settle_cycles = CNT_W'(`ADK_T2_MS * CYC_PER_MS);
			3'h3: settle_cycles = CNT_W'(`ADK_T3_MS * CYC_PER_MS);
			3'h4: settle_cycles = CNT_W'(`ADK_T4_MS * CYC_PER_MS);
			3'h5: settle_cycles = CNT_W'(`ADK_T5_MS * CYC_PER_MS);
			3'h6: settle_cycles = CNT_W'(`ADK_T6_MS * CYC_PER_MS);
			default: settle_cycles = CNT_W'(`ADK_T7_MS * CYC_PER_MS);
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			sense_d <= 1'b1;
		else
			sense_d <= accessory_sense_input_n;
	end

	// Detection sequencer; soft reset aborts whatever is running
	always_ff @(posedge clk_sys)
	begin
		if (rst || soft_rst)
		begin
			state <= ADK_IDLE;
			cnt   <= '0;
		end
		else
		begin
			case (state)
				ADK_IDLE:
				begin
					cnt <= '0;
					if (req_ok)
						state <= ADK_DETECT;
					else if (insert_edge && detctl[`ADK_DET_AUTO])
						state <= ADK_SETTLE;
				end
				ADK_SETTLE:
				begin
					if (!inserted)
						state <= ADK_IDLE;
					else if (cnt >= settle_cycles - 1'b1)
					begin
						cnt   <= '0;
						state <= ADK_DETECT;
					end
					else
						cnt <= cnt + 1'b1;
				end
				ADK_DETECT:
				begin
					if (cnt >= CNT_W'(DET_CYCLES - 1))
					begin
						cnt   <= '0;
						state <= ADK_IDLE;
					end
					else
						cnt <= cnt + 1'b1;
				end
				default: state <= ADK_IDLE;
			endcase
		end
	end

	assign detect_done = state == ADK_DETECT && cnt >= CNT_W'(DET_CYCLES - 1);

	// Detection control register
	always_ff @(posedge clk_sys)
	begin
		if (rst || soft_rst)
			detctl <= `ADK_DETCTL_RST;
		else if (wr_det)
		begin
			detctl <= reg_wdata;
			detctl[`ADK_DET_SWRST] <= 1'b0;
			// A refused request must not drop a detection that is still running
			detctl[`ADK_DET_REQ]   <= req_ok || (detctl[`ADK_DET_REQ] && detect_busy && !detect_done);
		end
		else if (detect_done)
			detctl[`ADK_DET_REQ] <= 1'b0;
	end

	// Key control register; removal clear wins over a host write
	always_ff @(posedge clk_sys)
	begin
		if (rst || soft_rst)
			keyctl <= 3'(`ADK_KEYCTL_RST);
		else if (accessory_removed)
			keyctl <= 3'h0;
		else
		begin
			if (wr_key)
			begin
				keyctl[`ADK_KEY_SENSE] <= reg_wdata[`ADK_KEY_SENSE];
				keyctl[`ADK_KEY_RAW]   <= reg_wdata[`ADK_KEY_RAW] & reg_wdata[`ADK_KEY_SENSE];
				if (reg_wdata[`ADK_KEY_CONV] && reg_wdata[`ADK_KEY_SENSE] && reg_wdata[`ADK_KEY_RAW])
					keyctl[`ADK_KEY_CONV] <= 1'b1;
				else if (!reg_wdata[`ADK_KEY_SENSE] || !reg_wdata[`ADK_KEY_RAW])
					keyctl[`ADK_KEY_CONV] <= 1'b0;
			end
			else if (key_evt.conv_done)
				keyctl[`ADK_KEY_CONV] <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst || soft_rst)
			conv_busy <= 1'b0;
		else if (conv_start)
			conv_busy <= 1'b1;
		else if (key_evt.conv_done || !keyctl[`ADK_KEY_CONV])
			conv_busy <= 1'b0;
	end

	assign conv_start = keyctl[`ADK_KEY_CONV] && !conv_busy;

	// Event flags; a new event wins over a clear in the same cycle
	always_ff @(posedge clk_sys)
	begin
		if (rst || soft_rst)
		begin
			key_press_flag   <= 1'b0;
			key_release_flag <= 1'b0;
			conv_flag        <= 1'b0;
			conv_result      <= 8'h00;
		end
		else
		begin
			if (sense_on && raw_on && key_evt.press)
				key_press_flag <= 1'b1;
			else if (!sense_on || (reg_rd && reg_addr == `ADK_OFS_STATUS))
				key_press_flag <= 1'b0;
			if (sense_on && raw_on && key_evt.release_)
				key_release_flag <= 1'b1;
			else if (!sense_on || key_evt.press || (reg_rd && reg_addr == `ADK_OFS_STATUS))
				key_release_flag <= 1'b0;
			if (key_evt.conv_done && conv_busy)
			begin
				conv_flag   <= 1'b1;
				conv_result <= key_evt.conv_value;
			end
			else if (reg_rd && reg_addr == `ADK_OFS_STATUS)
				conv_flag <= 1'b0;
		end
	end

	// Button detection gated by the third matrix under host override
	assign button_detect_run = sense_on && (!detctl[`ADK_DET_OVR] || third_switch_matrix == 2'b01
		|| third_switch_matrix == 2'b10);

	always_comb
	begin
		switch_state = detctl[`ADK_DET_OVR] ? switch_ctl : switch_auto;
		depletion_on = inserted ? !detctl[`ADK_DET_RADIO] : 1'b1;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (reg_rd && reg_addr == `ADK_OFS_DETCTL)
			reg_rdata <= detctl;
		else if (reg_rd && reg_addr == `ADK_OFS_KEYCTL)
			reg_rdata <= {5'h00, keyctl} & `ADK_KEYCTL_MASK;
		else if (reg_rd)
			reg_rdata <= 8'h00;
	end

	a_req_refused: assert property (@(posedge clk_sys) disable iff (rst)
		wr_det && reg_wdata[`ADK_DET_REQ] && !reg_wdata[`ADK_DET_SWRST] && int_status != 8'h00 && !detect_busy
		|=> !detctl[`ADK_DET_REQ]) else $error("request taken with status pending");
	a_req_empty: assert property (@(posedge clk_sys) disable iff (rst)
		wr_det && !reg_wdata[`ADK_DET_SWRST] && accessory_sense_input_n && !detect_busy
		|=> !detctl[`ADK_DET_REQ] && !detect_busy) else $error("request taken with no accessory");
	a_req_clear: assert property (@(posedge clk_sys) disable iff (rst)
		detect_done && !wr_det |=> !detctl[`ADK_DET_REQ]) else $error("request bit not cleared");
	a_swrst_zero: assert property (@(posedge clk_sys) disable iff (rst)
		soft_rst |=> detctl == `ADK_DETCTL_RST && keyctl == 3'h0 && state == ADK_IDLE)
		else $error("soft reset incomplete");
	a_raw_follow: assert property (@(posedge clk_sys) disable iff (rst)
		!sense_on |-> !raw_on) else $error("raw mode without sensing");
	a_flag_clear: assert property (@(posedge clk_sys) disable iff (rst)
		$fell(sense_on) |=> !key_press_flag && !key_release_flag) else $error("key flags kept");
	a_remove_clr: assert property (@(posedge clk_sys) disable iff (rst)
		accessory_removed && !soft_rst |=> !sense_on) else $error("sense kept after removal");
	a_override_sw: assert property (@(posedge clk_sys) disable iff (rst)
		detctl[`ADK_DET_OVR] |-> switch_state == switch_ctl) else $error("override not applied");
	a_auto_off: assert property (@(posedge clk_sys) disable iff (rst)
		state == ADK_IDLE && insert_edge && !detctl[`ADK_DET_AUTO] && !wr_det |=> state == ADK_IDLE)
		else $error("auto detection while off");
	a_conv_gate: assert property (@(posedge clk_sys) disable iff (rst)
		conv_start |-> sense_on && raw_on) else $error("conversion without enables");
	a_req_hold: assert property (@(posedge clk_sys) disable iff (rst)
		detect_busy && detctl[`ADK_DET_REQ] && !detect_done && !soft_rst |=> detctl[`ADK_DET_REQ])
		else $error("request bit dropped during detection");
	a_conv_clear: assert property (@(posedge clk_sys) disable iff (rst)
		key_evt.conv_done && !wr_key && !accessory_removed && !soft_rst |=> !keyctl[`ADK_KEY_CONV])
		else $error("conversion request not cleared");
	a_conv_load: assert property (@(posedge clk_sys) disable iff (rst)
		key_evt.conv_done && conv_busy && !soft_rst |=> conv_flag && conv_result == $past(key_evt.conv_value))
		else $error("conversion result not loaded");
	a_depl_radio: assert property (@(posedge clk_sys) disable iff (rst)
		inserted && detctl[`ADK_DET_RADIO] |-> !depletion_on) else $error("depletion on in radio mode");
	a_run_matrix: assert property (@(posedge clk_sys) disable iff (rst)
		detctl[`ADK_DET_OVR] && third_switch_matrix == 2'b00 |-> !button_detect_run)
		else $error("button detection in wrong matrix position");
endmodule
`default_nettype wire

// ---- adk_defs.svh ----
`ifndef ADK_DEFS_SVH
`define ADK_DEFS_SVH
`define ADK_OFS_STATUS  8'h02
`define ADK_OFS_DETCTL  8'h04
`define ADK_OFS_KEYCTL  8'h05
`define ADK_DET_SWRST   7
`define ADK_DET_OVR     6
`define ADK_DET_AUTO    5
`define ADK_DET_REQ     4
`define ADK_DET_RADIO   3
`define ADK_KEY_SENSE   2
`define ADK_KEY_RAW     1
`define ADK_KEY_CONV    0
`define ADK_DETCTL_RST  8'h23
`define ADK_KEYCTL_RST  8'h00
`define ADK_KEYCTL_MASK 8'h07
`define ADK_CLK_KHZ     20000
`define ADK_T0_MS       2
`define ADK_T1_MS       30
`define ADK_T2_MS       60
`define ADK_T3_MS       90
`define ADK_T4_MS       120
`define ADK_T5_MS       150
`define ADK_T6_MS       1000
`define ADK_T7_MS       2000
`endif

// ---- adk_pkg.sv ----
package adk_pkg;
	typedef enum logic [1:0] {ADK_IDLE, ADK_SETTLE, ADK_DETECT} adk_det_state_t;
	typedef struct packed {
		logic sw1;
		logic sw2;
		logic ring_dep;
		logic sleeve_dep;
		logic ring_gnd;
		logic sleeve_gnd;
	} adk_switch_t;
	typedef struct packed {
		logic       press;
		logic       release_;
		logic       conv_done;
		logic [7:0] conv_value;
	} adk_key_evt_t;
endpackage

// ---- adk_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module adk_host_model (
	input  wire logic       clk_sys,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata,
	input  wire logic [7:0] reg_rdata
);
	initial
	begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'hff;
		reg_wdata = 8'h00;
	end
	// No pacing here: a conversion may be requested again before its flag is serviced
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		// Released data must not look like a stale valid byte
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask
endmodule
`default_nettype wire

// ---- test_adk_ctrl_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_adk_ctrl_regs;
	import adk_pkg::*;
	localparam int DET = 16;
	logic         clk_sys, rst, reg_wr, reg_rd, sense_n, removed;
	logic [7:0]   reg_addr, reg_wdata, reg_rdata, int_status, conv_result, d;
	logic [1:0]   matrix;
	adk_switch_t  sw_ctl, sw_auto, sw_state;
	adk_key_evt_t key_evt;
	logic         depl, busy, done, run, conv_start, kp, kr, cf, dev_rst;
	logic [31:0]  seed;
	int           n_mismatch, compares, n, m_det, m_key;
	adk_host_model adk_host_model_inst (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	adk_ctrl_regs #(.CLK_KHZ(1), .DET_CYCLES(DET)) adk_ctrl_regs_inst (.clk_sys(clk_sys), .rst(rst),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.int_status(int_status), .accessory_sense_input_n(sense_n), .accessory_removed(removed),
		.switch_ctl(sw_ctl), .switch_auto(sw_auto), .third_switch_matrix(matrix), .key_evt(key_evt),
		.switch_state(sw_state), .depletion_on(depl), .detect_busy(busy), .detect_done(done),
		.button_detect_run(run), .conv_start(conv_start), .key_press_flag(kp), .key_release_flag(kr),
		.conv_flag(cf), .conv_result(conv_result), .device_reset(dev_rst));
	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic final_report();
		if (n_mismatch == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic rc(input logic [7:0] a, input int e);
		adk_host_model_inst.rd(a, d);
		chk(d, e[7:0]);
	endtask
	task automatic wr(input logic [7:0] a, input int v);
		adk_host_model_inst.wr(a, v[7:0]);
	endtask
	// Kind 0 press, 1 release, 2 conversion done, 3 removal
	task automatic pulse(input int k, input logic [7:0] v);
		@(negedge clk_sys);
		key_evt.press = (k == 0);
		key_evt.release_ = (k == 1);
		key_evt.conv_done = (k == 2);
		key_evt.conv_value = v;
		removed = (k == 3);
		@(negedge clk_sys);
		key_evt = {3'b000, ~v};
		removed = 1'b0;
	endtask
	task automatic wait_done();
		n = 0;
		while (done !== 1'b1 && n < 300)
		begin
			@(negedge clk_sys);
			n++;
		end
		if (n == 300)
		begin
			n_mismatch++;
			final_report();
		end
	endtask
	initial
	begin
		{reg_wr, reg_rd, removed, sense_n, matrix, int_status} = '0;
		key_evt = '0;
		seed = 32'h6450;
		sw_ctl = seed[5:0];
		sw_auto = ~seed[5:0];
		n_mismatch = 0;
		compares = 0;
		m_det = 'h23;
		m_key = 0;
		rst = 1'b1;
		repeat (4) @(negedge clk_sys);
		rst = 1'b0;
		rc(8'h04, m_det);
		rc(8'h05, m_key);
		wr(8'h04, 'h6b);
		chk(sw_state, sw_ctl);
		chk(depl, 0);
		wr(8'h04, 'h03);
		chk(sw_state, sw_auto);
		chk(depl, 1);
		sense_n = 1'b1;
		wr(8'h04, 'h13);
		rc(8'h04, 'h03);
		sense_n = 1'b0;
		@(negedge clk_sys);
		chk(busy, 0);
		int_status = 8'h01;
		wr(8'h04, 'h13);
		rc(8'h04, 'h03);
		int_status = 8'h00;
		wr(8'h04, 'h13);
		chk(busy, 1);
		rc(8'h04, 'h13);
		wr(8'h04, 'h13);
		rc(8'h04, 'h13);
		wait_done();
		chk(n < DET - 1, 1);
		@(negedge clk_sys);
		chk(busy, 0);
		rc(8'h04, 'h03);
		wr(8'h04, 'h80);
		rc(8'h04, 'h23);
		wr(8'h05, 'h04);
		wr(8'h04, 'h63);
		for (int m = 0; m < 4; m++)
		begin
			matrix = m[1:0];
			@(negedge clk_sys);
			chk(run, m == 1 || m == 2);
		end
		wr(8'h04, 'h23);
		wr(8'h05, 'h06);
		pulse(0, 8'h00);
		chk(kp, 1);
		wr(8'h05, 'h06);
		chk(kp, 1);
		pulse(1, 8'h00);
		chk(kr, 1);
		repeat (2)
		begin
			seed = lfsr(seed);
			wr(8'h05, 'h07);
			chk(conv_start, 1);
			pulse(2, seed[7:0]);
			chk({cf, conv_result}, {1'b1, seed[7:0]});
			rc(8'h05, 'h06);
		end
		wr(8'h05, 'h03);
		chk(conv_start, 0);
		rc(8'h05, 'h00);
		chk({kp, kr}, 0);
		wr(8'h05, 'h06);
		pulse(0, 8'h00);
		chk(kp, 1);
		pulse(3, 8'h00);
		rc(8'h05, 'h00);
		chk(kp, 0);
		wr(8'h04, 'h20);
		sense_n = 1'b1;
		@(negedge clk_sys);
		sense_n = 1'b0;
		wait_done();
		chk(n >= DET, 1);
		final_report();
	end
endmodule
`default_nettype wire
